// >>> verilog/flash_host_defines.vh
// Purpose: Constants for the flash bus host controller
// Assumes: 250 MHz system clock, 4 ns period
// Notes:   Timing counts derive from ns figures and the clock period
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ==========================================================
// Bus geometry
`define ADDR_W          22
`define DATA_W          16
`define SECTOR_MSB      21
`define SECTOR_LSB      15
`define PROT_DIR_BIT    6
`define PROT_KEY_HI_BIT 1
`define PROT_KEY_LO_BIT 0

// ==========================================================
// Timing
`define CLK_PERIOD_NS   4
`define ACCESS_NS       70
`define WE_PULSE_NS     35
`define SETUP_NS        8
`define RESET_PULSE_NS  500
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_CYC    ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Operation codes
`define OP_READ         2'h0
`define OP_WRITE        2'h1
`define OP_PROTECT      2'h2
`define OP_RESET        2'h3

`endif

// >>> verilog/flash_pin_sync.v
// Purpose: Two flip-flop synchroniser for the shared data bus inputs
// Assumes: Inputs change asynchronously to i_clk_sys
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module flash_pin_sync
#(
  parameter WIDTH = 16
)
(
  input  wire             i_clk_sys,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// >>> verilog/flash_bus_host.v
// Purpose: Host-side controller driving a parallel 16-bit flash bus
// Assumes: Device pins are wired straight to the o_/i_ pin ports
// Notes:   One request at a time; o_busy high while a cycle runs
// What this block does
// - Read: select and output enable low
// - Keep write enable high while reading
// - Protect write: key bits and elevated protect voltage level
// - Data bus direction follows write phase
// - Command: write and select low, output high
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_bus_host
#(
  parameter ADDR_W     = `ADDR_W,
  parameter DATA_W     = `DATA_W,
  parameter ACCESS_CYC = `ACCESS_CYC,
  parameter WE_CYC     = `WE_PULSE_CYC,
  parameter SETUP_CYC  = `SETUP_CYC,
  parameter RESET_CYC  = `RESET_PULSE_CYC
)
(
  input  wire              i_clk_sys,
  input  wire              i_rstn,
  input  wire              i_req,
  input  wire [1:0]        i_op,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [DATA_W-1:0] i_wdata,
  input  wire              i_protect_dir,
  output reg               o_busy,
  output reg               o_done,
  output reg  [DATA_W-1:0] o_rdata,
  output reg               o_chip_select_n,
  output reg               o_output_enable_n,
  output reg               o_write_enable_n,
  output reg               o_hardware_reset_n,
  output reg               o_protect_voltage_level,
  output reg  [ADDR_W-1:0] o_word_address_in,
  input  wire [DATA_W-1:0] i_data_io,
  output reg  [DATA_W-1:0] o_data_io,
  output reg               o_data_io_oe
);

  // ==========================================================
  // States
  localparam ST_IDLE   = 3'h0;
  localparam ST_SETUP  = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_HOLD   = 3'h3;
  localparam ST_RESET  = 3'h4;

  // Counter sized for the default reset pulse
  // A longer RESET_CYC needs a wider counter
  localparam CNT_W = 10;

  reg [2:0]       state_q;
  reg [1:0]       op_q;
  reg [CNT_W-1:0] cnt_q;
  wire [DATA_W-1:0] data_sync;

  flash_pin_sync
  #(
    .WIDTH (DATA_W)
  )
  u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_async   (i_data_io),
    .o_sync    (data_sync)
  );

  // Sector and key bits forced for protect cycles
  function [ADDR_W-1:0] protect_addr;
    input [ADDR_W-1:0] a;
    input              dir;
    reg   [ADDR_W-1:0] r;
    begin
      r = {ADDR_W{1'b0}};
      r[`SECTOR_MSB:`SECTOR_LSB] = a[`SECTOR_MSB:`SECTOR_LSB];
      r[`PROT_DIR_BIT]    = dir;
      r[`PROT_KEY_HI_BIT] = 1'b1;
      r[`PROT_KEY_LO_BIT] = 1'b0;
      protect_addr = r;
    end
  endfunction

  // ==========================================================
  // Sequencer
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q                 <= ST_IDLE;
      op_q                    <= `OP_READ;
      cnt_q                   <= {CNT_W{1'b0}};
      o_busy                  <= 1'b0;
      o_done                  <= 1'b0;
      o_rdata                 <= {DATA_W{1'b0}};
      o_chip_select_n         <= 1'b1;
      o_output_enable_n       <= 1'b1;
      o_write_enable_n        <= 1'b1;
      o_hardware_reset_n      <= 1'b1;
      o_protect_voltage_level <= 1'b0;
      o_word_address_in       <= {ADDR_W{1'b0}};
      o_data_io               <= {DATA_W{1'b0}};
      o_data_io_oe            <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (i_req)
          begin
            op_q   <= i_op;
            o_busy <= 1'b1;
            cnt_q  <= SETUP_CYC[CNT_W-1:0];
            if (i_op == `OP_RESET)
            begin
              // Device aborts and returns to array read while low
              o_hardware_reset_n <= 1'b0;
              cnt_q              <= RESET_CYC[CNT_W-1:0];
              state_q            <= ST_RESET;
            end
            else
            begin
              // Address set before any strobe so it is latched on the fall
              o_chip_select_n   <= 1'b0;
              o_word_address_in <= (i_op == `OP_PROTECT) ?
                                   protect_addr(i_addr, i_protect_dir) : i_addr;
              o_protect_voltage_level <= (i_op == `OP_PROTECT);
              o_data_io    <= i_wdata;
              o_data_io_oe <= (i_op != `OP_READ);
              state_q      <= ST_SETUP;
            end
          end
        end
        ST_SETUP:
        begin
          if (cnt_q > 1)
            cnt_q <= cnt_q - 1'b1;
          else
          begin
            if (op_q == `OP_READ)
            begin
              o_output_enable_n <= 1'b0;
              o_write_enable_n  <= 1'b1;
              cnt_q             <= ACCESS_CYC[CNT_W-1:0];
            end
            else
            begin
              o_output_enable_n <= 1'b1;
              o_write_enable_n  <= 1'b0;
              cnt_q             <= WE_CYC[CNT_W-1:0];
            end
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          // Sync adds two cycles, but the count is ACCESS_CYC alone and does not add the sync cycles
          if (cnt_q > 1)
            cnt_q <= cnt_q - 1'b1;
          else
          begin
            if (op_q == `OP_READ)
              o_rdata <= data_sync;
            o_output_enable_n <= 1'b1;
            // Data still driven across the rising edge: latched there
            o_write_enable_n  <= 1'b1;
            cnt_q             <= SETUP_CYC[CNT_W-1:0];
            state_q           <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // Select and data kept past the strobe edge for device hold time
          if (cnt_q > 1)
            cnt_q <= cnt_q - 1'b1;
          else
          begin
            o_chip_select_n         <= 1'b1;
            o_data_io_oe            <= 1'b0;
            o_protect_voltage_level <= 1'b0;
            o_busy                  <= 1'b0;
            o_done                  <= 1'b1;
            state_q                 <= ST_IDLE;
          end
        end
        ST_RESET:
        begin
          if (cnt_q > 1)
            cnt_q <= cnt_q - 1'b1;
          else
          begin
            o_hardware_reset_n <= 1'b1;
            o_busy             <= 1'b0;
            o_done             <= 1'b1;
            state_q            <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> tb/flash_host_properties.sv
// Purpose: Pin-level checks on the flash host
// Assumes: One clock, reset active low
// Notes:   Bound to every flash_bus_host
`timescale 1ns/1ps
module flash_host_properties
(
  input wire        i_clk_sys,
  input wire        i_rstn,
  input wire        i_req,
  input wire        o_busy,
  input wire        o_done,
  input wire        o_chip_select_n,
  input wire        o_output_enable_n,
  input wire        o_write_enable_n,
  input wire        o_hardware_reset_n,
  input wire        o_protect_voltage_level,
  input wire [21:0] o_word_address_in,
  input wire        o_data_io_oe
);
  // ==========================================================
  // Checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence take_s; i_req && !o_busy; endsequence
  sequence prot_s; !o_write_enable_n && o_protect_voltage_level; endsequence
  read_sel_a: assert property (!o_output_enable_n |-> !o_chip_select_n)
    else $error("read strobe without select");
  read_we_a: assert property (!o_output_enable_n |-> o_write_enable_n)
    else $error("write strobe during read");
  cmd_levels_a: assert property (!o_write_enable_n |->
    o_output_enable_n && !o_chip_select_n)
    else $error("write strobe levels wrong");
  reset_quiet_a: assert property (!o_hardware_reset_n |->
    o_chip_select_n && o_output_enable_n && o_write_enable_n && !o_data_io_oe)
    else $error("strobe during device reset");
  drive_dir_a: assert property (o_data_io_oe |-> o_output_enable_n)
    else $error("host drives while reading");
  prot_key_a: assert property (prot_s |-> o_word_address_in[1:0] == 2'h2)
    else $error("protect key bits wrong");
  addr_hold_a: assert property (!o_chip_select_n [*2] |-> $stable(o_word_address_in))
    else $error("address moved in cycle");
  take_done_a: assert property (take_s |=> o_busy ##[1:200] o_done)
    else $error("request not completed");
endmodule
bind flash_bus_host flash_host_properties i_flash_host_properties (.i_clk_sys, .i_rstn,
  .i_req, .o_busy, .o_done, .o_chip_select_n, .o_output_enable_n, .o_write_enable_n,
  .o_hardware_reset_n, .o_protect_voltage_level, .o_word_address_in, .o_data_io_oe);

// >>> tb/flash_device_model.sv
// Purpose: Behavioural flash device on the host pins
// Assumes: Array data is a fixed function of the address
// Notes:   Undriven bus shows inverse data, so late samples fail
`timescale 1ns/1ps
module flash_device_model
(
  input  wire        i_cs_n,
  input  wire        i_oe_n,
  input  wire        i_we_n,
  input  wire        i_rst_n,
  input  wire        i_vid,
  input  wire [21:0] i_addr,
  input  wire [15:0] i_hd,
  input  wire        i_hoe,
  output wire [15:0] o_dq
);
  // ==========================================================
  // Command latch and mode
  reg  [1:0]   mode_q = 2'h0;
  reg  [127:0] prot_q = 128'h0;
  reg  [15:0]  cmd_q;
  reg  [21:0]  alat_q;
  wire [15:0]  rd = (mode_q == 2'h0) ? (i_addr[15:0] ^ {i_addr[21:15], 9'h0A5}) :
                    (mode_q == 2'h1) ? cmd_q : {15'h0, prot_q[i_addr[21:15]]};
  wire         drv = !i_cs_n && !i_oe_n && i_we_n && i_rst_n;
  assign o_dq = i_hoe ? i_hd : drv ? rd : ~rd;
  always @(negedge i_we_n or negedge i_cs_n)
    if (!i_we_n && !i_cs_n && i_rst_n)
      alat_q <= i_addr;
  always @(posedge i_we_n or posedge i_cs_n or negedge i_rst_n)
    if (!i_rst_n)
      mode_q <= 2'h0;
    else if (i_we_n ^ i_cs_n)
    begin
      if (i_vid && alat_q[1:0] == 2'h2)
      begin
        prot_q[alat_q[21:15]] <= ~alat_q[6];
        mode_q <= 2'h2;
      end
      else if (!i_vid)
      begin
        // Taken from the bus, so a host that forgot to drive is caught
        cmd_q <= o_dq;
        mode_q <= 2'h1;
      end
    end
endmodule

// >>> tb/flash_bus_operation_decoder_bench.sv
// Purpose: Self-checking bench for the flash host
// Assumes: Device model on the far side of the pins
// Notes:   Reset pulse shortened to 4 cycles
`timescale 1ns/1ps
`include "flash_host_defines.vh"
module flash_bus_operation_decoder_bench;
  // ==========================================================
  // Wiring
  reg         i_clk_sys = 1'b0;
  reg         i_rstn = 1'b0;
  reg         i_req = 1'b0;
  reg  [1:0]  i_op = 2'h0;
  reg  [21:0] i_addr = 22'h0;
  reg  [15:0] i_wdata = 16'h0;
  reg         i_protect_dir = 1'b0;
  wire [15:0] i_data_io, o_data_io, o_rdata;
  wire [21:0] o_word_address_in;
  wire        o_busy, o_done, o_chip_select_n, o_output_enable_n, o_write_enable_n;
  wire        o_hardware_reset_n, o_protect_voltage_level, o_data_io_oe;
  integer     mismatches = 0;
  integer     num_checks = 0;
  integer     n;
  // Edges from take to done: setup, strobe, hold
  localparam integer RST_CYC   = 4;
  localparam [15:0]  READ_CYC  = 16'(2 * `SETUP_CYC + `ACCESS_CYC);
  localparam [15:0]  WRITE_CYC = 16'(2 * `SETUP_CYC + `WE_PULSE_CYC);
  flash_bus_host #(.RESET_CYC(RST_CYC)) i_flash_bus_host (.i_clk_sys, .i_rstn, .i_req, .i_op,
    .i_addr, .i_wdata, .i_protect_dir, .o_busy, .o_done, .o_rdata, .o_chip_select_n,
    .o_output_enable_n, .o_write_enable_n, .o_hardware_reset_n, .o_protect_voltage_level,
    .o_word_address_in, .i_data_io, .o_data_io, .o_data_io_oe);
  flash_device_model i_flash_device_model (.i_cs_n(o_chip_select_n),
    .i_oe_n(o_output_enable_n), .i_we_n(o_write_enable_n), .i_rst_n(o_hardware_reset_n),
    .i_vid(o_protect_voltage_level), .i_addr(o_word_address_in), .i_hd(o_data_io),
    .i_hoe(o_data_io_oe), .o_dq(i_data_io));
  initial
    forever #2 i_clk_sys = ~i_clk_sys;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task check(input [47:0] what, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Bounded wait; n is cycles from take edge to done
  task run(input [1:0] op, input [21:0] a, input [15:0] d, input dir);
    integer k;
    begin
      @(posedge i_clk_sys);
      i_req <= 1'b1;
      i_op <= op;
      i_addr <= a;
      i_wdata <= d;
      i_protect_dir <= dir;
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      n = 0;
      for (k = 1; k < 300 && n == 0; k = k + 1)
      begin
        @(posedge i_clk_sys);
        #1;
        if (o_done === 1'b1)
          n = k;
      end
      if (n == 0)
      begin
        mismatches = mismatches + 1;
        $display("mismatch done expected 1 seen 0");
        conclude;
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_boot;
    begin
      run(2'h0, 22'h3FFFFF, 16'h0, 1'b0);
      check("cycles", READ_CYC, n[15:0]);
      check("data", 16'h015A, o_rdata);
      run(2'h0, 22'h000001, 16'h0, 1'b0);
      check("data", 16'h00A4, o_rdata);
      $display("t_boot done");
    end
  endtask
  task t_cmd;
    begin
      run(2'h1, 22'h000555, 16'h00AA, 1'b0);
      check("cycles", WRITE_CYC, n[15:0]);
      run(2'h0, 22'h000001, 16'h0, 1'b0);
      check("data", 16'h00AA, o_rdata);
      run(2'h3, 22'h0, 16'h0, 1'b0);
      check("cycles", 16'(RST_CYC), n[15:0]);
      run(2'h0, 22'h000001, 16'h0, 1'b0);
      check("data", 16'h00A4, o_rdata);
      $display("t_cmd done");
    end
  endtask
  task t_prot;
    begin
      run(2'h2, 22'h2A80FF, 16'h0, 1'b0);
      check("cycles", WRITE_CYC, n[15:0]);
      run(2'h0, 22'h2A8000, 16'h0, 1'b0);
      check("prot", 16'h0001, o_rdata);
      run(2'h0, 22'h000000, 16'h0, 1'b0);
      check("prot", 16'h0000, o_rdata);
      run(2'h2, 22'h2A8000, 16'h0, 1'b1);
      run(2'h0, 22'h2A8000, 16'h0, 1'b0);
      check("prot", 16'h0000, o_rdata);
      $display("t_prot done");
    end
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_boot;
    t_cmd;
    t_prot;
    conclude;
  end
endmodule
